// File: hw/vco_cal_timing_adc_control.sv
// Calibration timing registers, predivider, timers and converter control.
// Assumes a synchronous byte register port and an outside calibration sequencer.
`timescale 1ns/100ps
module vco_cal_timing_adc_control #(
    parameter int VCO_OVR_W   = 16,
    parameter int DEL_CTRL_W  = 8,
    parameter int CONV_CLOCKS = 16
) (
    input  wire logic                  clk_in,
    input  wire logic                  nrst_in,
    input  wire logic                  reg_wr_in,
    input  wire logic [7:0]            reg_addr_in,
    input  wire logic [7:0]            reg_wdata_in,
    output logic      [7:0]            reg_rdata_out,
    input  wire logic                  cal_start_in,
    input  wire logic                  cal_busy_in,
    input  wire logic                  settle_start_in,
    input  wire logic                  level_start_in,
    output logic                       div_tick_out,
    output logic                       decision_done_out,
    output logic                       settle_done_out,
    output logic                       level_done_out,
    output logic                       conv_enable_out,
    output logic                       conv_start_out,
    output logic                       conv_clk_out,
    output logic                       conv_busy_out,
    input  wire logic [VCO_OVR_W-1:0]  vco_override_in,
    input  wire logic [DEL_CTRL_W-1:0] delay_ctrl_in,
    input  wire logic                  buffer_update_in,
    output logic      [VCO_OVR_W-1:0]  vco_override_out,
    output logic      [DEL_CTRL_W-1:0] delay_ctrl_out
);
    generate
        if (CONV_CLOCKS < 1 || CONV_CLOCKS > 255 || VCO_OVR_W < 1 || DEL_CTRL_W < 1) begin : g_chk
            $error("vco_cal_timing_adc_control: unsupported parameter value");
        end
    endgenerate
    // Register file
    logic [7:0] decision_reg, decision_next;
    logic [7:0] settle_lo_reg, settle_lo_next;
    logic [7:0] settle_hi_reg, settle_hi_next;
    logic [7:0] level_lo_reg, level_lo_next;
    logic [7:0] level_hi_reg, level_hi_next;
    logic [7:0] conv_div_reg, conv_div_next;
    logic [7:0] conv_ctrl_reg, conv_ctrl_next;
    logic [7:0] prediv_reg, prediv_next;
    logic [7:0] rdata_next;
    logic       trigger_wr;
    always_comb begin
        decision_next  = decision_reg;
        settle_lo_next = settle_lo_reg;
        settle_hi_next = settle_hi_reg;
        level_lo_next  = level_lo_reg;
        level_hi_next  = level_hi_reg;
        conv_div_next  = conv_div_reg;
        conv_ctrl_next = conv_ctrl_reg;
        prediv_next    = prediv_reg;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                vco_cal_timing_pkg::OFS_DECISION:  decision_next  = reg_wdata_in;
                vco_cal_timing_pkg::OFS_SETTLE_LO: settle_lo_next = reg_wdata_in;
                vco_cal_timing_pkg::OFS_SETTLE_HI: settle_hi_next = reg_wdata_in;
                vco_cal_timing_pkg::OFS_LEVEL_LO:  level_lo_next  = reg_wdata_in;
                vco_cal_timing_pkg::OFS_LEVEL_HI:  level_hi_next  = reg_wdata_in;
                vco_cal_timing_pkg::OFS_CONV_DIV:  conv_div_next  = reg_wdata_in;
                vco_cal_timing_pkg::OFS_CONV_CTRL: conv_ctrl_next = reg_wdata_in;
                vco_cal_timing_pkg::OFS_PREDIV:    prediv_next    = reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Manual trigger is a write strobe, not stored
    assign trigger_wr = reg_wr_in && (reg_addr_in == vco_cal_timing_pkg::OFS_TRIGGER)
                        && reg_wdata_in[vco_cal_timing_pkg::TRIGGER_BIT]; // R11
    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr_in)
            vco_cal_timing_pkg::OFS_DECISION:  rdata_next = decision_reg;
            vco_cal_timing_pkg::OFS_SETTLE_LO: rdata_next = settle_lo_reg;
            vco_cal_timing_pkg::OFS_SETTLE_HI: rdata_next = settle_hi_reg;
            vco_cal_timing_pkg::OFS_LEVEL_LO:  rdata_next = level_lo_reg;
            vco_cal_timing_pkg::OFS_LEVEL_HI:  rdata_next = level_hi_reg;
            vco_cal_timing_pkg::OFS_CONV_DIV:  rdata_next = conv_div_reg;
            vco_cal_timing_pkg::OFS_CONV_CTRL: rdata_next = conv_ctrl_reg;
            vco_cal_timing_pkg::OFS_PREDIV:    rdata_next = prediv_reg;
            vco_cal_timing_pkg::OFS_STATUS: begin
                rdata_next[vco_cal_timing_pkg::CONV_BUSY_BIT] = conv_busy_out; // R12
                rdata_next[vco_cal_timing_pkg::CAL_BUSY_BIT]  = cal_busy_in;   // R13
            end
            default: ;
        endcase
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            decision_reg  <= vco_cal_timing_pkg::REG_RESET;
            settle_lo_reg <= vco_cal_timing_pkg::REG_RESET;
            settle_hi_reg <= vco_cal_timing_pkg::REG_RESET;
            level_lo_reg  <= vco_cal_timing_pkg::REG_RESET;
            level_hi_reg  <= vco_cal_timing_pkg::REG_RESET;
            conv_div_reg  <= vco_cal_timing_pkg::REG_RESET;
            conv_ctrl_reg <= vco_cal_timing_pkg::REG_RESET;
            prediv_reg    <= vco_cal_timing_pkg::REG_RESET;
            reg_rdata_out <= 8'h00;
        end else begin
            decision_reg  <= decision_next;
            settle_lo_reg <= settle_lo_next;
            settle_hi_reg <= settle_hi_next;
            level_lo_reg  <= level_lo_next;
            level_hi_reg  <= level_hi_next;
            conv_div_reg  <= conv_div_next;
            conv_ctrl_reg <= conv_ctrl_next;
            prediv_reg    <= prediv_next;
            reg_rdata_out <= rdata_next;
        end
    end
    // Predivider and calibration timers
    logic [2:0]  pre_cnt_reg, pre_cnt_next, pre_lim;
    logic [1:0]  pre_code;
    logic        tick;
    logic [11:0] dec_per_reg, dec_per_next, dec_cnt_reg, dec_cnt_next;
    logic [14:0] settle_cnt_reg, settle_cnt_next, level_cnt_reg, level_cnt_next;
    logic        dec_done_next, settle_done_next, level_done_next;
    logic [14:0] settle_val, level_val;
    logic [4:0]  dec_age_reg, dec_age_next; // Check helper, idle at 5'h1F
    assign pre_code   = prediv_reg[vco_cal_timing_pkg::PREDIV_LSB +: 2];
    assign pre_lim    = 3'((4'h1 << pre_code) - 4'h1); // R10
    assign tick       = (pre_cnt_reg >= pre_lim);
    assign settle_val = {settle_hi_reg[6:0], settle_lo_reg}; // R2
    assign level_val  = {level_hi_reg[6:0], level_lo_reg};   // R3
    always_comb begin
        pre_cnt_next     = tick ? 3'h0 : pre_cnt_reg + 3'h1;
        dec_per_next     = dec_per_reg;
        dec_cnt_next     = dec_cnt_reg;
        settle_cnt_next  = settle_cnt_reg;
        level_cnt_next   = level_cnt_reg;
        dec_done_next    = 1'b0;
        settle_done_next = 1'b0;
        level_done_next  = 1'b0;
        dec_age_next     = 5'h1F;
        if (cal_start_in) begin
            dec_per_next = {decision_reg, 4'h0}; // R1 R15
            dec_cnt_next = {decision_reg, 4'h0};
        end else if (!cal_busy_in) begin
            dec_cnt_next = 12'h000;
        end else if (tick && dec_cnt_reg != 12'h000) begin
            dec_cnt_next = dec_cnt_reg - 12'h001;
            if (dec_cnt_reg == 12'h001) begin
                dec_done_next = 1'b1; // R1
                dec_cnt_next  = dec_per_reg;
            end
        end
        if (settle_start_in) begin
            settle_cnt_next = (settle_val == 15'h0000) ? 15'h0001 : settle_val; // R15
        end else if (tick && settle_cnt_reg != 15'h0000) begin
            settle_cnt_next  = settle_cnt_reg - 15'h0001;
            settle_done_next = (settle_cnt_reg == 15'h0001); // R2
        end
        if (level_start_in) begin
            level_cnt_next = (level_val == 15'h0000) ? 15'h0001 : level_val; // R15
        end else if (tick && level_cnt_reg != 15'h0000) begin
            level_cnt_next  = level_cnt_reg - 15'h0001;
            level_done_next = (level_cnt_reg == 15'h0001); // R3
        end
        if (cal_start_in) begin
            dec_age_next = (decision_reg == 8'h01 && pre_code == 2'b00) ? 5'h00 : 5'h1F;
        end else if (dec_age_reg < 5'h10 && cal_busy_in && pre_code == 2'b00) begin
            dec_age_next = dec_age_reg + 5'h01;
        end
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_cnt_reg       <= 3'h0;
            dec_per_reg       <= 12'h000;
            dec_cnt_reg       <= 12'h000;
            settle_cnt_reg    <= 15'h0000;
            level_cnt_reg     <= 15'h0000;
            dec_age_reg       <= 5'h1F;
            div_tick_out      <= 1'b0;
            decision_done_out <= 1'b0;
            settle_done_out   <= 1'b0;
            level_done_out    <= 1'b0;
        end else begin
            pre_cnt_reg       <= pre_cnt_next;
            dec_per_reg       <= dec_per_next;
            dec_cnt_reg       <= dec_cnt_next;
            settle_cnt_reg    <= settle_cnt_next;
            level_cnt_reg     <= level_cnt_next;
            dec_age_reg       <= dec_age_next;
            div_tick_out      <= tick;
            decision_done_out <= dec_done_next;
            settle_done_out   <= settle_done_next;
            level_done_out    <= level_done_next;
        end
    end
    // Temperature converter sequencing
    vco_cal_timing_pkg::conv_state_t conv_state_reg, conv_state_next;
    logic [9:0] cper_reg, cper_next, ccnt_reg, ccnt_next;
    logic [7:0] edges_reg, edges_next;
    logic       conv_en, conv_permit, start_req, clk_edge_next;
    assign conv_en     = conv_ctrl_reg[vco_cal_timing_pkg::ENABLE_BIT];
    assign conv_permit = conv_ctrl_reg[vco_cal_timing_pkg::PERMIT_BIT];
    assign start_req   = trigger_wr // R9 R11
                         || (cal_start_in && conv_ctrl_reg[vco_cal_timing_pkg::AUTO_BIT]); // R8
    always_comb begin
        conv_state_next = conv_state_reg;
        cper_next       = cper_reg;
        ccnt_next       = ccnt_reg;
        edges_next      = edges_reg;
        clk_edge_next   = 1'b0;
        unique case (conv_state_reg)
            vco_cal_timing_pkg::CONV_IDLE: begin
                if (start_req && conv_en && conv_permit) begin // R7
                    conv_state_next = vco_cal_timing_pkg::CONV_RUN;
                    cper_next = 10'(vco_cal_timing_pkg::CONV_DIV_MUL * conv_div_reg
                                    + vco_cal_timing_pkg::CONV_DIV_ADD); // R14 R15
                    ccnt_next  = 10'h000;
                    edges_next = 8'h00;
                end
            end
            vco_cal_timing_pkg::CONV_RUN: begin
                if (!conv_en || !conv_permit) begin
                    conv_state_next = vco_cal_timing_pkg::CONV_IDLE; // R7
                end else if (tick) begin
                    ccnt_next = ccnt_reg + 10'h001;
                    if (ccnt_reg == cper_reg - 10'h001) begin
                        ccnt_next     = 10'h000;
                        clk_edge_next = 1'b1; // R14
                        edges_next    = edges_reg + 8'h01;
                        if (edges_reg == 8'(CONV_CLOCKS - 1)) begin
                            conv_state_next = vco_cal_timing_pkg::CONV_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            conv_state_reg  <= vco_cal_timing_pkg::CONV_IDLE;
            cper_reg        <= 10'h000;
            ccnt_reg        <= 10'h000;
            edges_reg       <= 8'h00;
            conv_clk_out    <= 1'b0;
            conv_start_out  <= 1'b0;
            conv_busy_out   <= 1'b0;
            conv_enable_out <= 1'b0;
        end else begin
            conv_state_reg  <= conv_state_next;
            cper_reg        <= cper_next;
            ccnt_reg        <= ccnt_next;
            edges_reg       <= edges_next;
            conv_clk_out    <= clk_edge_next;
            conv_start_out  <= (conv_state_reg == vco_cal_timing_pkg::CONV_IDLE)
                               && (conv_state_next == vco_cal_timing_pkg::CONV_RUN);
            conv_busy_out   <= (conv_state_next == vco_cal_timing_pkg::CONV_RUN); // R12
            conv_enable_out <= conv_ctrl_next[vco_cal_timing_pkg::ENABLE_BIT]; // R7
        end
    end

    // Double buffered override paths
    logic [VCO_OVR_W-1:0]  vco_hold_reg, vco_hold_next;
    logic [DEL_CTRL_W-1:0] del_hold_reg, del_hold_next;
    logic                  vco_db, del_db;
    assign vco_db = settle_hi_reg[vco_cal_timing_pkg::BUF_BIT];
    assign del_db = level_hi_reg[vco_cal_timing_pkg::BUF_BIT];
    always_comb begin
        vco_hold_next = buffer_update_in ? vco_override_in : vco_hold_reg;
        del_hold_next = buffer_update_in ? delay_ctrl_in : del_hold_reg;
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            vco_hold_reg     <= '0;
            del_hold_reg     <= '0;
            vco_override_out <= '0;
            delay_ctrl_out   <= '0;
        end else begin
            vco_hold_reg     <= vco_hold_next;
            del_hold_reg     <= del_hold_next;
            vco_override_out <= vco_db ? vco_hold_next : vco_override_in; // R4
            delay_ctrl_out   <= del_db ? del_hold_next : delay_ctrl_in;   // R5
        end
    end

    // Checks
    a_start_needs_permit: assert property (@(posedge clk_in) disable iff (!nrst_in) // R7
        conv_start_out |-> $past(conv_en && conv_permit))
        else $error("conversion started without enable and permit");
    a_permit_blocks: assert property (@(posedge clk_in) disable iff (!nrst_in) // R7
        (!conv_permit && conv_state_reg == vco_cal_timing_pkg::CONV_IDLE) |=> !conv_busy_out)
        else $error("conversion ran with permit clear");
    a_auto_start: assert property (@(posedge clk_in) disable iff (!nrst_in) // R8
        (cal_start_in && conv_ctrl_reg[0] && conv_en && conv_permit && !conv_busy_out
         && conv_state_reg == vco_cal_timing_pkg::CONV_IDLE) |=> conv_start_out)
        else $error("auto conversion missing at calibration start");
    a_no_auto_start: assert property (@(posedge clk_in) disable iff (!nrst_in) // R9
        (conv_start_out && !$past(trigger_wr)) |-> $past(conv_ctrl_reg[0] && cal_start_in))
        else $error("conversion started without a trigger");
    a_trigger_start: assert property (@(posedge clk_in) disable iff (!nrst_in) // R11
        (trigger_wr && conv_en && conv_permit
         && conv_state_reg == vco_cal_timing_pkg::CONV_IDLE) |=> conv_start_out ##1 conv_busy_out)
        else $error("manual trigger did not start a conversion");
    a_busy_status: assert property (@(posedge clk_in) disable iff (!nrst_in) // R12
        (reg_addr_in == vco_cal_timing_pkg::OFS_STATUS) |=> reg_rdata_out[2] == $past(conv_busy_out))
        else $error("converter busy status wrong");
    a_cal_status: assert property (@(posedge clk_in) disable iff (!nrst_in) // R13
        (reg_addr_in == vco_cal_timing_pkg::OFS_STATUS) |=> reg_rdata_out[1] == $past(cal_busy_in))
        else $error("calibration busy status wrong");
    a_prediv_one: assert property (@(posedge clk_in) disable iff (!nrst_in) // R10
        (pre_code == 2'b00 && $stable(pre_code)) |=> div_tick_out)
        else $error("divide by one not ticking every cycle");
    a_settle_one: assert property (@(posedge clk_in) disable iff (!nrst_in) // R2
        (settle_start_in && settle_val == 15'h0001 && pre_code == 2'b00) ##1
        (pre_code == 2'b00 && !settle_start_in) |=> settle_done_out)
        else $error("settle timeout of one tick missed");
    a_level_one: assert property (@(posedge clk_in) disable iff (!nrst_in) // R3
        (level_start_in && level_val == 15'h0001 && pre_code == 2'b00) ##1
        (pre_code == 2'b00 && !level_start_in) |=> level_done_out)
        else $error("level timeout of one tick missed");
    a_decision_len: assert property (@(posedge clk_in) disable iff (!nrst_in) // R1
        (dec_age_reg == 5'h10) |-> decision_done_out)
        else $error("decision step length wrong");
    a_vco_direct: assert property (@(posedge clk_in) disable iff (!nrst_in) // R4
        !vco_db |=> vco_override_out == $past(vco_override_in))
        else $error("override not passed directly");
    a_del_hold: assert property (@(posedge clk_in) disable iff (!nrst_in) // R5
        (del_db && !buffer_update_in) |=> delay_ctrl_out == $past(del_hold_reg))
        else $error("buffered delay control changed without update");
    c_manual_conv: cover property (@(posedge clk_in) disable iff (!nrst_in)
        trigger_wr ##[1:3] conv_start_out);
    c_auto_conv: cover property (@(posedge clk_in) disable iff (!nrst_in)
        cal_start_in ##1 conv_start_out);
    c_conv_clock: cover property (@(posedge clk_in) disable iff (!nrst_in)
        conv_busy_out ##1 conv_clk_out);
endmodule

// File: hw/vco_cal_timing_pkg.sv
// Constants for the calibration timing and temperature converter control block.
// Assumes register writes arrive one byte at a time from the serial port core.
//
// What this block does
// R1 - Each calibration decision step lasts 16 times the decision divider, in divided ticks.
// R2 - DAC settle timeout equals the 15-bit settle value, in divided reference ticks.
// R3 - Level control phase times out after the 15-bit level timeout value.
// R4 - Settle high bit 7 set double buffers manual core, band and bias overrides.
// R5 - Level high bit 7 set double buffers output invert and bleed controls.
// R6 - Software keeps converter clock under 400 kHz through the divider formula.
// R7 - Converter runs only with enable bit 1; conversions need permit bit 7.
// R8 - Auto convert bit set starts a conversion at each calibration start.
// R9 - Auto convert bit clear allows conversions only from the manual trigger.
// R10 - Divided reference clock comes from a 2-bit predivider: 1, 2, 4 or 8.
// R11 - Writing trigger bit 0 starts one converter conversion.
// R12 - Converter busy status bit 2 reads 1 during a conversion.
// R13 - Calibration busy status bit 1 reads 1 during a calibration.
// R14 - Converter clock period is four times divider plus two divided ticks.
// R15 - Timeouts and dividers are sampled at start; later writes do not alter counts.
package vco_cal_timing_pkg;
    localparam logic [7:0] OFS_DECISION   = 8'h37;
    localparam logic [7:0] OFS_SETTLE_LO  = 8'h38;
    localparam logic [7:0] OFS_SETTLE_HI  = 8'h39;
    localparam logic [7:0] OFS_LEVEL_LO   = 8'h3A;
    localparam logic [7:0] OFS_LEVEL_HI   = 8'h3B;
    localparam logic [7:0] OFS_CONV_DIV   = 8'h3E;
    localparam logic [7:0] OFS_CONV_CTRL  = 8'h3F;
    localparam logic [7:0] OFS_PREDIV     = 8'h4E;
    localparam logic [7:0] OFS_TRIGGER    = 8'h54;
    localparam logic [7:0] OFS_STATUS     = 8'h58;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam int         BUF_BIT        = 7;
    localparam int         PERMIT_BIT     = 7;
    localparam int         ENABLE_BIT     = 1;
    localparam int         AUTO_BIT       = 0;
    localparam int         TRIGGER_BIT    = 0;
    localparam int         CONV_BUSY_BIT  = 2;
    localparam int         CAL_BUSY_BIT   = 1;
    localparam int         PREDIV_LSB     = 4;
    localparam int         DECISION_SHIFT = 4;
    localparam int         CONV_DIV_MUL   = 4;
    localparam int         CONV_DIV_ADD   = 2;
    typedef enum logic {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } conv_state_t;
endpackage

// File: verif/tb_top.sv
// Self-checking bench for the calibration timing and converter control block.
// Assumes the byte register port, strobe inputs and pulse outputs of the block.
`timescale 1ns/100ps
module tb_top;
    localparam int NCONV = 16;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        reg_wr_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic [7:0]  reg_rdata_out;
    logic        cal_start_in = 1'b0;
    logic        cal_busy_in = 1'b0;
    logic        settle_start_in = 1'b0;
    logic        level_start_in = 1'b0;
    logic        buffer_update_in = 1'b0;
    logic [15:0] vco_override_in = 16'h0000;
    logic [7:0]  delay_ctrl_in = 8'h00;
    logic [15:0] vco_override_out;
    logic [7:0]  delay_ctrl_out;
    logic        div_tick_out, decision_done_out, settle_done_out, level_done_out;
    logic        conv_enable_out, conv_start_out, conv_clk_out, conv_busy_out;
    logic [7:0]  regs [7] = '{8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3E, 8'h3F};
    int          miscompares = 0;
    int          checked = 0;
    int          n, p;

    always #20 clk_in = ~clk_in;

    vco_cal_timing_adc_control #(.VCO_OVR_W(16), .DEL_CTRL_W(8), .CONV_CLOCKS(NCONV)) dut (
        .clk_in, .nrst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
        .cal_start_in, .cal_busy_in, .settle_start_in, .level_start_in, .div_tick_out,
        .decision_done_out, .settle_done_out, .level_done_out, .conv_enable_out,
        .conv_start_out, .conv_clk_out, .conv_busy_out, .vco_override_in, .delay_ctrl_in,
        .buffer_update_in, .vco_override_out, .delay_ctrl_out);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        @(posedge clk_in);
        @(negedge clk_in);
        chk(16'(reg_rdata_out), 16'(e));
    endtask
    // One-cycle strobe: 0 settle, 1 level, 2 calibration start, else buffer load
    task automatic strobe(input int w);
        @(posedge clk_in);
        case (w)
            0: settle_start_in <= 1'b1;
            1: level_start_in <= 1'b1;
            2: cal_start_in <= 1'b1;
            default: buffer_update_in <= 1'b1;
        endcase
        @(posedge clk_in);
        settle_start_in <= 1'b0;
        level_start_in <= 1'b0;
        cal_start_in <= 1'b0;
        buffer_update_in <= 1'b0;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return div_tick_out;
            1: return decision_done_out;
            2: return settle_done_out;
            3: return level_done_out;
            default: return conv_clk_out;
        endcase
    endfunction
    // Cycles until the chosen pulse is seen, bounded
    task automatic wait_for(input int w, output int c);
        c = 0;
        do begin
            @(negedge clk_in);
            c++;
        end while (pick(w) !== 1'b1 && c < 3000);
    endtask
    task automatic try_start(input logic [7:0] ctl, input bit by_cal, input logic exp);
        wr(8'h3F, ctl);
        if (by_cal) strobe(2);
        else wr(8'h54, 8'h01);
        @(negedge clk_in);
        chk(16'(conv_start_out), 16'(exp));
        @(negedge clk_in);
        chk(16'(conv_busy_out), 16'(exp));
        chk(16'(conv_enable_out), 16'(ctl[1]));
    endtask
    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #800000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 7; i++) rd(regs[i], 8'h00);
        rd(8'h40, 8'h00);
        for (int i = 0; i < 7; i++) wr(regs[i], 8'h5A ^ 8'(i));
        for (int i = 0; i < 7; i++) rd(regs[i], 8'h5A ^ 8'(i));
        for (int c = 0; c < 4; c++) begin
            wr(8'h4E, 8'(c << 4));
            repeat (2) wait_for(0, n);
            wait_for(0, n);
            chk(16'(n), 16'(1 << c));
        end
        wr(8'h4E, 8'h00);
        // High bit 7 is the buffering flag, not part of the count
        wr(8'h38, 8'h05);
        wr(8'h39, 8'h81);
        strobe(0);
        wait_for(2, n);
        chk(16'(n), 16'd262);
        wr(8'h3A, 8'h02);
        wr(8'h3B, 8'h01);
        strobe(1);
        wr(8'h3A, 8'hFF);
        wait_for(3, n);
        chk(16'(n), 16'd257);
        wr(8'h38, 8'h01);
        wr(8'h39, 8'h00);
        wr(8'h3A, 8'h01);
        wr(8'h3B, 8'h00);
        for (int k = 0; k < 2; k++) begin
            strobe(k);
            wait_for(k + 2, n);
            chk(16'(n), 16'd2);
        end
        wr(8'h37, 8'h01);
        cal_busy_in <= 1'b1;
        strobe(2);
        wait_for(1, n);
        wait_for(1, n);
        chk(16'(n), 16'd16);
        rd(8'h58, 8'h02);
        @(posedge clk_in);
        cal_busy_in <= 1'b0;
        wr(8'h3E, 8'h01);
        try_start(8'h81, 0, 1'b0);
        try_start(8'h03, 0, 1'b0);
        try_start(8'h82, 1, 1'b0);
        try_start(8'h82, 0, 1'b1);
        n = 0;
        p = 0;
        while (conv_busy_out === 1'b1 && p < 500) begin
            @(negedge clk_in);
            p++;
            if (conv_clk_out === 1'b1) n++;
        end
        chk(16'(n), 16'(NCONV));
        try_start(8'h83, 1, 1'b1);
        wait_for(4, n);
        wait_for(4, n);
        chk(16'(n), 16'd6);
        rd(8'h58, 8'h04);
        wr(8'h3F, 8'h02);
        repeat (2) @(negedge clk_in);
        chk(16'(conv_busy_out), 16'h0000);
        wr(8'h39, 8'h00);
        wr(8'h3B, 8'h00);
        vco_override_in <= 16'h1234;
        delay_ctrl_in <= 8'h34;
        repeat (3) @(negedge clk_in);
        chk(vco_override_out, 16'h1234);
        chk(16'(delay_ctrl_out), 16'h0034);
        wr(8'h39, 8'h80);
        wr(8'h3B, 8'h80);
        strobe(3);
        vco_override_in <= 16'h5678;
        delay_ctrl_in <= 8'h78;
        repeat (3) @(negedge clk_in);
        chk(vco_override_out, 16'h1234);
        chk(16'(delay_ctrl_out), 16'h0034);
        strobe(3);
        repeat (3) @(negedge clk_in);
        chk(vco_override_out, 16'h5678);
        chk(16'(delay_ctrl_out), 16'h0078);
        tally_and_finish();
    end
endmodule
